// >>> design/mac_i2c_slave.sv
// Behaviour
// - Answer address 110011x, pin sets D1
// - Eighth address bit selects write or read
// - Data changes only while clock low
// - Detect start and stop while clock high
// - Bus busy from start until stop
// - Repeated start restarts address reception
// - Bytes are eight bits, MSB first
// - Ninth pulse carries acknowledge from receiver
// - Acknowledge every received byte once addressed
// - Write: address, register select, data
// - Apply write at final acknowledge rise
// - Channel register: gain, mute, enable fields
// - Post register: gain, source; top zero
// - Rising calibration bit starts calibration
// - Gain code default 0111, 2 dB steps
// - Bit 4 mutes mic one, bit 5 two
module mac_i2c_slave (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_addr_sel,
  // Amplifier controls
  output logic [3:0] o_preamp_gain_code,
  output logic [1:0] o_mic_mute,
  output logic [1:0] o_mic_enable,
  output logic [2:0] o_post_gain,
  output logic [1:0] o_source_select,
  output logic o_cal_request,
  output logic o_cal_start,
  output logic o_bus_busy
);
  mac_pkg::mac_state_type s_r;
  mac_pkg::mac_state_type s_nxt;
  logic [1:0] addr_sync_r;
  logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] rx_byte, tx_byte;

  // Register read decode, reserved bits zero
  function automatic logic [7:0] read_reg(input logic [7:0] ptr, input mac_pkg::mac_state_type st);
    case (ptr)
      mac_pkg::OFS_CHANNEL: read_reg = st.channel;
      mac_pkg::OFS_POST: read_reg = st.post & mac_pkg::MASK_POST;
      mac_pkg::OFS_CAL: read_reg = st.cal & mac_pkg::MASK_CAL;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Address select pin synchroniser
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      addr_sync_r <= 2'h0;
    end else begin
      addr_sync_r <= {addr_sync_r[0], i_addr_sel};
    end
  end

  // Edge and condition detection on the synchronised pins
  always_comb begin
    scl = s_r.pins.scl_sync[1];
    sda = s_r.pins.sda_sync[1];
    scl_rise = scl && !s_r.pins.scl_d;
    scl_fall = !scl && s_r.pins.scl_d;
    start_cond = scl && s_r.pins.scl_d && s_r.pins.sda_d && !sda;
    stop_cond = scl && s_r.pins.scl_d && !s_r.pins.sda_d && sda;
    rx_byte = {s_r.shift[6:0], sda};
    tx_byte = read_reg(s_r.reg_ptr, s_r);
  end

  // Protocol engine; SCL edges sampled here are a few clocks late, well inside hold time
  always_comb begin
    s_nxt = s_r;
    s_nxt.pins.scl_sync = {s_r.pins.scl_sync[0], i_scl};
    s_nxt.pins.sda_sync = {s_r.pins.sda_sync[0], i_sda};
    s_nxt.pins.scl_d = scl;
    s_nxt.pins.sda_d = sda;
    s_nxt.cal_start = 1'b0;
    if (start_cond) begin
      s_nxt.phase = mac_pkg::MAC_ADDR;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.byte_idx = 2'h0;
      s_nxt.busy = 1'b1;
      s_nxt.sda_low = 1'b0;
      s_nxt.pend_valid = 1'b0;
    end else if (stop_cond) begin
      s_nxt.phase = mac_pkg::MAC_IDLE;
      s_nxt.busy = 1'b0;
      s_nxt.sda_low = 1'b0;
    end else begin
      case (s_r.phase)
        mac_pkg::MAC_IDLE, mac_pkg::MAC_IGNORE: begin
          s_nxt.sda_low = 1'b0;
        end
        mac_pkg::MAC_ADDR, mac_pkg::MAC_RX: begin
          if (scl_rise) begin
            s_nxt.shift = rx_byte;
            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
          end
          if (scl_fall && s_r.bit_cnt == mac_pkg::BYTE_BITS) begin
            s_nxt.bit_cnt = 4'h0;
            if (s_r.phase == mac_pkg::MAC_ADDR) begin
              if (s_r.shift[7:2] == mac_pkg::ADDR_HIGH && s_r.shift[1] == addr_sync_r[1]) begin
                s_nxt.reading = s_r.shift[0];
                s_nxt.sda_low = 1'b1;
                s_nxt.phase = mac_pkg::MAC_ACK;
              end else begin
                s_nxt.phase = mac_pkg::MAC_IGNORE;
              end
            end else begin
              // Acknowledge every received byte
              s_nxt.sda_low = 1'b1;
              s_nxt.phase = mac_pkg::MAC_ACK;
              if (s_r.byte_idx == 2'h1) begin
                s_nxt.reg_ptr = s_r.shift;
              end else begin
                s_nxt.pending = s_r.shift;
                s_nxt.pend_valid = 1'b1;
              end
            end
          end
        end
        mac_pkg::MAC_ACK: begin
          // Write takes effect on the rising edge of our acknowledge
          if (scl_rise && s_r.pend_valid) begin
            s_nxt.pend_valid = 1'b0;
            case (s_r.reg_ptr)
              mac_pkg::OFS_CHANNEL: s_nxt.channel = s_r.pending;
              mac_pkg::OFS_POST: s_nxt.post = s_r.pending & mac_pkg::MASK_POST;
              mac_pkg::OFS_CAL: begin
                s_nxt.cal = s_r.pending & mac_pkg::MASK_CAL;
                s_nxt.cal_start = s_r.pending[mac_pkg::CAL_BIT] && !s_r.cal[mac_pkg::CAL_BIT];
              end
              default: s_nxt.pending = s_r.pending;
            endcase
          end
          if (scl_fall) begin
            s_nxt.byte_idx = (s_r.byte_idx == 2'h3) ? 2'h3 : s_r.byte_idx + 2'h1;
            if (s_r.reading) begin
              s_nxt.phase = mac_pkg::MAC_TX;
              s_nxt.shift = tx_byte;
              s_nxt.sda_low = !tx_byte[7];
              s_nxt.bit_cnt = 4'h1;
            end else begin
              s_nxt.phase = mac_pkg::MAC_RX;
              s_nxt.sda_low = 1'b0;
            end
          end
        end
        mac_pkg::MAC_TX: begin
          // Shift out on the falling edge only
          if (scl_fall) begin
            if (s_r.bit_cnt == mac_pkg::BYTE_BITS) begin
              s_nxt.sda_low = 1'b0;
              s_nxt.phase = mac_pkg::MAC_TXACK;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], 1'b0};
              s_nxt.sda_low = !s_r.shift[6];
              s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
          end
        end
        mac_pkg::MAC_TXACK: begin
          // Master ack sampled at rise; NACK leaves line released until the next start or stop
          if (scl_rise) begin
            s_nxt.phase = sda ? mac_pkg::MAC_IGNORE : mac_pkg::MAC_ACK;
          end
        end
        default: s_nxt.phase = mac_pkg::MAC_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.pins.scl_sync <= 2'h3;
      s_r.pins.sda_sync <= 2'h3;
      s_r.pins.scl_d <= 1'b1;
      s_r.pins.sda_d <= 1'b1;
      s_r.phase <= mac_pkg::MAC_IDLE;
      s_r.channel <= mac_pkg::RST_CHANNEL;
      s_r.post <= mac_pkg::RST_POST;
      s_r.cal <= mac_pkg::RST_CAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs from flip-flops, sda_out tied low; slave never drives start or stop
  always_comb begin
    o_sda_out = 1'b0;
    o_sda_oe = s_r.sda_low;
    o_preamp_gain_code = s_r.channel[mac_pkg::GAIN_LSB +: 4];
    o_mic_mute = s_r.channel[mac_pkg::MUTE_LSB +: 2];
    o_mic_enable = s_r.channel[mac_pkg::EN_LSB +: 2];
    o_post_gain = s_r.post[mac_pkg::POST_LSB +: 3];
    o_source_select = s_r.post[mac_pkg::SEL_LSB +: 2];
    o_cal_request = s_r.cal[mac_pkg::CAL_BIT];
    o_cal_start = s_r.cal_start;
    o_bus_busy = s_r.busy;
  end

  // Busy rises after a start
  a_busy_after_start: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) start_cond |=> o_bus_busy
  ) else $error("busy not set after start");

  // Stop frees the bus and the line
  a_idle_after_stop: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) stop_cond |=> !o_bus_busy && !o_sda_oe
  ) else $error("bus not idle after stop");

  // Any start restarts address reception
  a_restart_addr: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) start_cond |=> s_r.phase == mac_pkg::MAC_ADDR && s_r.bit_cnt == 4'h0
  ) else $error("restart ignored");

  // Our drive never moves while the clock is high
  a_sda_stable_high: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) (scl && s_r.pins.scl_d && !start_cond && !stop_cond) |=> $stable(o_sda_oe)
  ) else $error("sda moved in high");

  // Unused bits of both narrow registers stay zero
  a_post_top_zero: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) s_r.post[7:5] == 3'h0 && s_r.cal[7:1] == 7'h0
  ) else $error("reserved bits set");

  // Channel register only changes at our acknowledge rise
  a_write_on_ack: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !$stable(s_r.channel) |-> $past(s_r.phase) == mac_pkg::MAC_ACK && $past(scl_rise)
  ) else $error("early write");

  // Start pulse only on a fresh request
  a_cal_pulse: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) o_cal_start |-> o_cal_request && !$past(o_cal_request)
  ) else $error("bad cal start");

  // Received bytes are acknowledged
  a_ack_driven: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) s_r.phase == mac_pkg::MAC_ACK && !s_r.reading |-> o_sda_oe
  ) else $error("ack missing");

  // Open drain: the pad only ever pulls low
  a_open_drain_low: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) o_sda_out == 1'b0
  ) else $error("sda driven high");

  // Line is only pulled in acknowledge or read data slots
  a_oe_in_slots: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_sda_oe |-> s_r.phase == mac_pkg::MAC_ACK || s_r.phase == mac_pkg::MAC_TX
  ) else $error("sda pulled outside slot");

  // Ninth pulse after a received byte carries our acknowledge
  a_ack_after_byte: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_r.phase == mac_pkg::MAC_RX && scl_fall && s_r.bit_cnt == mac_pkg::BYTE_BITS |=> o_sda_oe
  ) else $error("no ack after byte");

  // Master refusal ends the read and frees the line
  a_nack_release: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_r.phase == mac_pkg::MAC_TXACK && scl_rise && sda |=> s_r.phase == mac_pkg::MAC_IGNORE && !o_sda_oe
  ) else $error("line held after nack");

  // Foreign address traffic never sees our drive
  a_ignore_quiet: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) s_r.phase == mac_pkg::MAC_IGNORE |-> !o_sda_oe
  ) else $error("drive while ignoring");

  // Post register only changes at our acknowledge rise
  a_post_on_ack: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !$stable(s_r.post) |-> $past(s_r.phase) == mac_pkg::MAC_ACK && $past(scl_rise)
  ) else $error("early post write");

  // Bit counter never passes one byte
  a_bit_count_max: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) s_r.bit_cnt <= mac_pkg::BYTE_BITS
  ) else $error("bit count overrun");

  // Start pulse lasts one clock
  a_cal_one_cycle: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) o_cal_start |=> !o_cal_start
  ) else $error("cal start too long");

  // Second byte of a transfer selects the register
  a_ptr_from_select: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_r.phase == mac_pkg::MAC_RX && scl_fall && s_r.bit_cnt == mac_pkg::BYTE_BITS && s_r.byte_idx == 2'h1
    |=> s_r.reg_ptr == $past(s_r.shift)
  ) else $error("register select lost");

  // Calibration register keeps only its trigger bit
  a_cal_top_zero: assert property (
    @(posedge i_clock) disable iff (!i_rst_n) s_r.cal[7:1] == 7'h0
  ) else $error("cal reserved bits set");
endmodule

// >>> design/mac_pkg.sv
package mac_pkg;
  // Slave address, upper six bits fixed, bit D1 from the select pin
  localparam logic [5:0] ADDR_HIGH = 6'h33;
  // Register offsets
  localparam logic [7:0] OFS_CHANNEL = 8'h01;
  localparam logic [7:0] OFS_POST = 8'h02;
  localparam logic [7:0] OFS_CAL = 8'h12;
  // Reset values
  localparam logic [7:0] RST_CHANNEL = 8'hc7;
  localparam logic [7:0] RST_POST = 8'h00;
  localparam logic [7:0] RST_CAL = 8'h00;
  // Field positions and writable masks
  localparam int GAIN_LSB = 0;
  localparam int MUTE_LSB = 4;
  localparam int EN_LSB = 6;
  localparam int POST_LSB = 0;
  localparam int SEL_LSB = 3;
  localparam int CAL_BIT = 0;
  localparam logic [7:0] MASK_POST = 8'h1f;
  localparam logic [7:0] MASK_CAL = 8'h01;
  // Bit count of one byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    MAC_IDLE, MAC_ADDR, MAC_ACK, MAC_RX, MAC_TX, MAC_TXACK, MAC_IGNORE
  } mac_phase_type;

  // Registered pin samples
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
  } mac_pins_type;

  // Whole slave state
  typedef struct packed {
    mac_pins_type pins;
    mac_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic reading;
    logic [7:0] reg_ptr;
    logic [7:0] pending;
    logic pend_valid;
    logic sda_low;
    logic busy;
    logic [7:0] channel;
    logic [7:0] post;
    logic [7:0] cal;
    logic cal_start;
  } mac_state_type;
endpackage

// >>> test/mac_bus_master.sv
module mac_bus_master (
  // Clock and wired data level
  input wire logic i_clock,
  input wire logic i_sda_wire,
  // Bus drive, pull-low style on data
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Phases of 12 clocks leave room for the slave's sync latency
  localparam int HALF = 12;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // All changes land on the falling clock edge
  task automatic wait_half();
    repeat (HALF) @(negedge i_clock);
  endtask
  // Start or repeated start from any idle or low clock phase
  task automatic start();
    o_sda_low = 1'b0;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    o_sda_low = 1'b1;
    wait_half();
    o_scl = 1'b0;
  endtask
  // Stop, also issued after a refused byte
  task automatic stop();
    o_sda_low = 1'b1;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    o_sda_low = 1'b0;
    wait_half();
  endtask
  // Data moves only with the clock low
  task automatic bit_xfer(input logic b, output logic got);
    o_sda_low = !b;
    wait_half();
    o_scl = 1'b1;
    wait_half();
    got = i_sda_wire;
    o_scl = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge pulse
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
                           output logic ack_in);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(!ack_out, got);
    ack_in = !got;
  endtask
endmodule

// >>> test/mac_i2c_slave_tb_top.sv
module mac_i2c_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic addr_sel = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, sda_wire, cal_req, cal_start, busy;
  logic [3:0] gain;
  logic [1:0] mute, en, sel;
  logic [2:0] post;
  logic [7:0] dev = 8'hcc;
  logic [7:0] d;
  logic ack;
  int n_mismatch = 0;
  int check_count = 0;
  int cal_cnt = 0;
  always #5 clock = ~clock;
  // Wired-and of both pull-downs, pull-up otherwise
  assign sda_wire = !sda_low && !(sda_oe && !sda_out);
  mac_bus_master m (.i_clock(clock), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_low(sda_low));
  mac_i2c_slave dut (.i_clock(clock), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_wire), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_addr_sel(addr_sel), .o_preamp_gain_code(gain), .o_mic_mute(mute),
    .o_mic_enable(en), .o_post_gain(post), .o_source_select(sel), .o_cal_request(cal_req),
    .o_cal_start(cal_start), .o_bus_busy(busy));
  // Count start pulses; a level would count many
  always @(posedge clock) if (cal_start === 1'b1) cal_cnt++;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address and register select, shared by writes and reads
  task automatic select(input logic [7:0] a);
    m.start();
    check({7'h00, busy}, 8'h01);
    m.xfer_byte(dev, 1'b0, d, ack);
    check({7'h00, ack}, 8'h01);
    m.xfer_byte(a, 1'b0, d, ack);
    check({7'h00, ack}, 8'h01);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    select(a);
    m.xfer_byte(v, 1'b0, d, ack);
    check({7'h00, ack}, 8'h01);
    m.stop();
    check({5'h00, sda_out, sda_oe, busy}, 8'h00);
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    select(a);
    m.start();
    m.xfer_byte(dev | 8'h01, 1'b0, d, ack);
    check({7'h00, ack}, 8'h01);
    m.xfer_byte(8'hff, 1'b0, v, ack);
    m.stop();
    check({7'h00, sda_oe}, 8'h00);
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check({en, mute, gain}, 8'hc7);
    check({busy, sda_oe, cal_req, sel, post}, 8'h00);
    reg_write(8'h01, 8'h5a);
    check({en, mute, gain}, 8'h5a);
    reg_write(8'h01, 8'h10);
    check({en, mute, gain}, 8'h10);
    reg_write(8'h02, 8'hff);
    check({sel, post}, 8'h1f);
    reg_read(8'h02, d);
    check(d, 8'h1f);
    reg_write(8'h12, 8'hff);
    reg_write(8'h12, 8'h01);
    check({cal_cnt[6:0], cal_req}, 8'h03);
    reg_read(8'h12, d);
    check(d, 8'h01);
    reg_write(8'h05, 8'haa);
    reg_read(8'h05, d);
    check(d, 8'h00);
    // Other address: no acknowledge while the pin selects the first
    dev = 8'hce;
    m.start();
    m.xfer_byte(dev, 1'b0, d, ack);
    check({7'h00, ack}, 8'h00);
    m.stop();
    addr_sel = 1'b1;
    reg_write(8'h01, 8'h33);
    check({en, mute, gain}, 8'h33);
    reg_read(8'h01, d);
    check(d, 8'h33);
    // Two-byte read: master acknowledges the first, refuses the second
    select(8'h01);
    m.start();
    m.xfer_byte(dev | 8'h01, 1'b0, d, ack);
    check({7'h00, ack}, 8'h01);
    m.xfer_byte(8'hff, 1'b1, d, ack);
    check(d, 8'h33);
    m.xfer_byte(8'hff, 1'b0, d, ack);
    check(d, 8'h33);
    m.stop();
    check({7'h00, sda_oe}, 8'h00);
    finish_test();
  end
endmodule
